// file: src/ppfc_edge_detect.sv
// Falling edge detector on the level seen by a DMA request input.
// Assumes the level is synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ppfc_edge_detect (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic level_in,
  output logic edge_pulse
);
  logic prev_level;

  // Previous level, idle high so reset raises no edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prev_level <= 1'b1;
    end else begin
      prev_level <= level_in;
    end
  end

  // One-cycle pulse on high to low
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= prev_level & ~level_in;
    end
  end
endmodule : ppfc_edge_detect
`default_nettype wire

// file: src/ppfc_params.svh
// Constants of the port pin function controller: offsets, fields, resets, codes.
// Assumes a 4-bit word address on the plain register port and 16-bit registers.
`ifndef PPFC_PARAMS_SVH
`define PPFC_PARAMS_SVH

// Register word addresses
`define PPFC_ADDR_PULLUP_A_HIGH 4'h0
`define PPFC_ADDR_MODE_C_LOW2 4'h1
`define PPFC_ADDR_MODE_E_LOW 4'h2
`define PPFC_ADDR_LEVEL_F_LOW 4'h3
`define PPFC_ADDR_PORT_DATA 4'h4
`define PPFC_ADDR_PORT_DIR 4'h5
`define PPFC_ADDR_PORT_LEVEL 4'h6

// Bit masks of implemented bits, everything else reads as zero
`define PPFC_MASK_PULLUP 16'h003f
`define PPFC_MASK_MODE_C 16'h7777
`define PPFC_MASK_MODE_E 16'h0770
`define PPFC_MASK_LEVEL_F 16'h00ff
`define PPFC_MASK_PORT 16'h003f

// Field positions
`define PPFC_C4_LSB 0
`define PPFC_E9_LSB 4
`define PPFC_E10_LSB 8

// Reset values
`define PPFC_RST_PULLUP 16'h0000
`define PPFC_RST_MODE_C 16'h0000
`define PPFC_RST_MODE_C_EXT 16'h1111
`define PPFC_RST_MODE_E 16'h0000
`define PPFC_RST_PORT 16'h0000

// Function codes of the three-bit mode fields
`define PPFC_FN_PORT 3'h0
`define PPFC_FN_ADDR 3'h1
`define PPFC_FN_DMA 3'h2
`define PPFC_FN_TIMER 3'h4
`define PPFC_FN_SPI 3'h5
`define PPFC_FN_SERIAL 3'h6
`define PPFC_FN_ETH 3'h7

`endif

// file: src/ppfc_pin_cell.sv
// Output mux of one multiplexed pin: the mode code picks value and enable.
// Assumes the caller ties prohibited codes to a zero enable.
`timescale 1ns/100ps
`default_nettype none
module ppfc_pin_cell
  import ppfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ppfc_code_type fn_code,
  input wire logic [7:0] fn_out,
  input wire logic [7:0] fn_oe,
  output logic pin_out,
  output logic pin_oe
);
  // Registered selection, pin released during reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= fn_out[fn_code];
      pin_oe <= fn_oe[fn_code];
    end
  end
endmodule : ppfc_pin_cell
`default_nettype wire

// file: src/ppfc_pkg.sv
// Types shared by the port pin function controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ppfc_pkg;
  typedef logic [2:0] ppfc_code_type;
  typedef logic [15:0] ppfc_reg_type;
  typedef logic [3:0] ppfc_addr_type;
endpackage : ppfc_pkg

// file: src/ppfc_top.sv
// Port pin function controller: pull-up enables, pin mode decode, port F levels.
// Assumes registers on a plain strobe port, pins and peripherals synchronous to clk_sys.
//
// Function
// - Each upper port A pull-up is on while its enable bit is 1, off while 0, reset 0.
// - Reserved bits read as zero and software writes zero to them.
// - Port C pin 7 field in bits 14 to 12: 000 port, 001 address bit 7, rest prohibited.
// - Port C pin 6 field in bits 10 to 8: 000 port, 001 address bit 6, rest prohibited.
// - Port C mode fields reset to 000, lowest bit 1 in external mode without internal ROM.
// - Port E pin 10: 000 port, 010 DMA request 3, 100 timer 3C, 101 SPI select 3, 110 serial tx, 111 Ethernet tx clock.
// - Port E pin 9: 000 port, 010 DMA acknowledge 2, 100 timer 3B, 111 Ethernet tx enable.
// - Switching a low pin from port to edge-sensed DMA request raises a detected edge.
// - Port F level register is 16 bits, read only, bits 7 to 0 are pins 7 to 0.
// - Writes to the port F level register are discarded.
// - A read of port F returns the live pin level, not a stored value.
// - A port F pin being sampled by the analog converter reads as 1.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ppfc_params.svh"
module ppfc_top
  import ppfc_pkg::*;
#(
  parameter int PORT_F_PINS = 8
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic strap_ext_rom_off,
  // Register port
  input wire ppfc_addr_type reg_addr,
  input wire ppfc_reg_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output ppfc_reg_type reg_rdata,
  // Port A pull-up controls
  output logic [5:0] pullup_en_a_high,
  // Port C pins 4 to 7
  input wire logic [3:0] pin_c_in,
  output logic [3:0] pin_c_out,
  output logic [3:0] pin_c_oe,
  // Port E pins 9 and 10
  input wire logic pin_e9_in,
  output logic pin_e9_out,
  output logic pin_e9_oe,
  input wire logic pin_e10_in,
  output logic pin_e10_out,
  output logic pin_e10_oe,
  // Port F pins and converter sampling flags
  input wire logic [PORT_F_PINS-1:0] pin_f_level,
  input wire logic [PORT_F_PINS-1:0] analog_sampling,
  // Peripheral sources
  input wire logic [3:0] ext_bus_addr_hi,
  input wire logic dma_acknowledge_2,
  input wire logic timer_ch3_io_b_out,
  input wire logic timer_ch3_io_b_oe,
  input wire logic timer_ch3_io_c_out,
  input wire logic timer_ch3_io_c_oe,
  input wire logic spi_slave_select_3,
  input wire logic serial_tx_2,
  input wire logic eth_tx_enable,
  // Peripheral sinks
  output logic dma_request_3_level,
  output logic dma_request_3_edge,
  output logic timer_ch3_io_b_in,
  output logic timer_ch3_io_c_in,
  output logic eth_tx_clk_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state

  ppfc_reg_type port_a_high_pullup_enable;
  ppfc_reg_type port_c_low_mode_select_2;
  ppfc_reg_type port_e_low_mode_select;
  ppfc_reg_type port_output_data;
  ppfc_reg_type port_direction;
  ppfc_reg_type next_rdata;
  ppfc_reg_type port_f_pin_level_low;
  ppfc_reg_type port_pin_level;
  ppfc_code_type pin_e9_function_code;
  ppfc_code_type pin_e10_function_code;
  logic [PORT_F_PINS-1:0] pin_f_read;
  logic dreq_gated;

  // Write decode per register
  logic wr_pullup;
  logic wr_mode_c;
  logic wr_mode_e;
  logic wr_data;
  logic wr_dir;

  assign wr_pullup = reg_write && (reg_addr == `PPFC_ADDR_PULLUP_A_HIGH);
  assign wr_mode_c = reg_write && (reg_addr == `PPFC_ADDR_MODE_C_LOW2);
  assign wr_mode_e = reg_write && (reg_addr == `PPFC_ADDR_MODE_E_LOW);
  assign wr_data = reg_write && (reg_addr == `PPFC_ADDR_PORT_DATA);
  assign wr_dir = reg_write && (reg_addr == `PPFC_ADDR_PORT_DIR);

  //////////////////////////////////////////////////////////////////////////////
  // Pull-up enables for port A pins 16 to 21

  // Only the six enable bits hold state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_a_high_pullup_enable <= `PPFC_RST_PULLUP;
    end else if (wr_pullup) begin
      port_a_high_pullup_enable <= reg_wdata & `PPFC_MASK_PULLUP;
    end
  end

  // Pull-up transistor controls follow the register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pullup_en_a_high <= 6'h00;
    end else begin
      pullup_en_a_high <= port_a_high_pullup_enable[5:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode registers

  // Port C fields: strap picks address function at reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      if (strap_ext_rom_off) begin
        port_c_low_mode_select_2 <= `PPFC_RST_MODE_C_EXT;
      end else begin
        port_c_low_mode_select_2 <= `PPFC_RST_MODE_C;
      end
    end else if (wr_mode_c) begin
      port_c_low_mode_select_2 <= reg_wdata & `PPFC_MASK_MODE_C;
    end
  end

  // Port E fields for pins 9 and 10
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_e_low_mode_select <= `PPFC_RST_MODE_E;
    end else if (wr_mode_e) begin
      port_e_low_mode_select <= reg_wdata & `PPFC_MASK_MODE_E;
    end
  end

  assign pin_e9_function_code = port_e_low_mode_select[`PPFC_E9_LSB +: 3];
  assign pin_e10_function_code = port_e_low_mode_select[`PPFC_E10_LSB +: 3];

  //////////////////////////////////////////////////////////////////////////////
  // General port data and direction, bits 3:0 port C pins 4 to 7, 4 pin E9, 5 pin E10

  // Output latch
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_output_data <= `PPFC_RST_PORT;
    end else if (wr_data) begin
      port_output_data <= reg_wdata & `PPFC_MASK_PORT;
    end
  end

  // Direction, 1 drives the pin
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_direction <= `PPFC_RST_PORT;
    end else if (wr_dir) begin
      port_direction <= reg_wdata & `PPFC_MASK_PORT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port C pins 4 to 7: port or external address output

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port_c
      logic [7:0] c_out;
      logic [7:0] c_oe;
      // Codes 010 to 111 leave the pin undriven
      always_comb begin
        c_out = 8'h00;
        c_oe = 8'h00;
        c_out[`PPFC_FN_PORT] = port_output_data[gi];
        c_oe[`PPFC_FN_PORT] = port_direction[gi];
        c_out[`PPFC_FN_ADDR] = ext_bus_addr_hi[gi];
        c_oe[`PPFC_FN_ADDR] = 1'b1;
      end
      ppfc_pin_cell u_cell (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .fn_code(port_c_low_mode_select_2[`PPFC_C4_LSB + 4*gi +: 3]),
        .fn_out(c_out),
        .fn_oe(c_oe),
        .pin_out(pin_c_out[gi]),
        .pin_oe(pin_c_oe[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Port E pin 10: port, DMA request, timer 3C, SPI select, serial tx, Ethernet clock

  logic [7:0] e10_out;
  logic [7:0] e10_oe;

  // Input-only functions and prohibited codes release the pin
  always_comb begin
    e10_out = 8'h00;
    e10_oe = 8'h00;
    e10_out[`PPFC_FN_PORT] = port_output_data[5];
    e10_oe[`PPFC_FN_PORT] = port_direction[5];
    e10_out[`PPFC_FN_TIMER] = timer_ch3_io_c_out;
    e10_oe[`PPFC_FN_TIMER] = timer_ch3_io_c_oe;
    e10_out[`PPFC_FN_SPI] = spi_slave_select_3;
    e10_oe[`PPFC_FN_SPI] = 1'b1;
    e10_out[`PPFC_FN_SERIAL] = serial_tx_2;
    e10_oe[`PPFC_FN_SERIAL] = 1'b1;
  end

  ppfc_pin_cell u_cell_e10 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .fn_code(pin_e10_function_code),
    .fn_out(e10_out),
    .fn_oe(e10_oe),
    .pin_out(pin_e10_out),
    .pin_oe(pin_e10_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Port E pin 9: port, DMA acknowledge, timer 3B, Ethernet tx enable

  logic [7:0] e9_out;
  logic [7:0] e9_oe;

  // Codes 001, 011, 101 and 110 release the pin
  always_comb begin
    e9_out = 8'h00;
    e9_oe = 8'h00;
    e9_out[`PPFC_FN_PORT] = port_output_data[4];
    e9_oe[`PPFC_FN_PORT] = port_direction[4];
    e9_out[`PPFC_FN_DMA] = dma_acknowledge_2;
    e9_oe[`PPFC_FN_DMA] = 1'b1;
    e9_out[`PPFC_FN_TIMER] = timer_ch3_io_b_out;
    e9_oe[`PPFC_FN_TIMER] = timer_ch3_io_b_oe;
    e9_out[`PPFC_FN_ETH] = eth_tx_enable;
    e9_oe[`PPFC_FN_ETH] = 1'b1;
  end

  ppfc_pin_cell u_cell_e9 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .fn_code(pin_e9_function_code),
    .fn_out(e9_out),
    .fn_oe(e9_oe),
    .pin_out(pin_e9_out),
    .pin_oe(pin_e9_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Inputs forwarded to peripherals

  // Request line idles high when not selected, so a low pin makes an edge on selection
  assign dreq_gated = (pin_e10_function_code == `PPFC_FN_DMA) ? pin_e10_in : 1'b1;

  // Registered levels seen by the peripherals, idle when their function is off
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dma_request_3_level <= 1'b1;
      timer_ch3_io_c_in <= 1'b0;
      eth_tx_clk_in <= 1'b0;
      timer_ch3_io_b_in <= 1'b0;
    end else begin
      dma_request_3_level <= dreq_gated;
      timer_ch3_io_c_in <= (pin_e10_function_code == `PPFC_FN_TIMER) && pin_e10_in;
      eth_tx_clk_in <= (pin_e10_function_code == `PPFC_FN_ETH) && pin_e10_in;
      timer_ch3_io_b_in <= (pin_e9_function_code == `PPFC_FN_TIMER) && pin_e9_in;
    end
  end

  // Edge on the gated request level
  ppfc_edge_detect u_dreq_edge (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .level_in(dreq_gated),
    .edge_pulse(dma_request_3_edge)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Live pin levels

  // Port F: each bit is the pin, or 1 while the converter samples it
  generate
    for (gi = 0; gi < PORT_F_PINS; gi++) begin : g_port_f
      assign pin_f_read[gi] = analog_sampling[gi] | pin_f_level[gi];
    end
  endgenerate

  // Upper bits reserved, zero
  always_comb begin
    port_f_pin_level_low = 16'h0000;
    port_f_pin_level_low[PORT_F_PINS-1:0] = pin_f_read;
    port_f_pin_level_low = port_f_pin_level_low & `PPFC_MASK_LEVEL_F;
  end

  // Port C and E pin levels in the port data layout
  assign port_pin_level = {10'h000, pin_e10_in, pin_e9_in, pin_c_in};

  //////////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the strobe only

  // Read mux, unmapped words read zero; port F has no write path at all
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      `PPFC_ADDR_PULLUP_A_HIGH: next_rdata = port_a_high_pullup_enable;
      `PPFC_ADDR_MODE_C_LOW2: next_rdata = port_c_low_mode_select_2;
      `PPFC_ADDR_MODE_E_LOW: next_rdata = port_e_low_mode_select;
      `PPFC_ADDR_LEVEL_F_LOW: next_rdata = port_f_pin_level_low;
      `PPFC_ADDR_PORT_DATA: next_rdata = port_output_data;
      `PPFC_ADDR_PORT_DIR: next_rdata = port_direction;
      `PPFC_ADDR_PORT_LEVEL: next_rdata = port_pin_level;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : ppfc_top
`default_nettype wire

// file: verif/ppfc_board_model.sv
// Board pins and on-chip peripherals around the port pin function controller.
// Assumes pin outputs and enables come from ppfc_top, board levels from the bench.
`timescale 1ns/100ps
`default_nettype none
module ppfc_board_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] board_c,
  input wire logic board_e9,
  input wire logic board_e10,
  input wire logic [3:0] pin_c_out,
  input wire logic [3:0] pin_c_oe,
  input wire logic pin_e9_out,
  input wire logic pin_e9_oe,
  input wire logic pin_e10_out,
  input wire logic pin_e10_oe,
  output logic [3:0] pin_c_in,
  output logic pin_e9_in,
  output logic pin_e10_in,
  output logic [3:0] ext_bus_addr_hi,
  output logic dma_acknowledge_2,
  output logic timer_ch3_io_b_out,
  output logic timer_ch3_io_b_oe,
  output logic timer_ch3_io_c_out,
  output logic timer_ch3_io_c_oe,
  output logic spi_slave_select_3,
  output logic serial_tx_2,
  output logic eth_tx_enable
);
  logic [15:0] pattern;
  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral sources change every cycle so a stale mux shows up
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pattern <= 16'h5a3c;
    end else begin
      pattern <= {pattern[14:0], pattern[15] ^ pattern[13] ^ pattern[12] ^ pattern[10]};
    end
  end
  assign {ext_bus_addr_hi, dma_acknowledge_2, timer_ch3_io_b_out} = pattern[5:0];
  assign {timer_ch3_io_b_oe, timer_ch3_io_c_out, timer_ch3_io_c_oe} = pattern[9:7];
  assign {spi_slave_select_3, serial_tx_2, eth_tx_enable} = pattern[13:11];
  // Wire level: a driving controller wins, otherwise the board sets the pin
  assign pin_c_in = (pin_c_oe & pin_c_out) | (~pin_c_oe & board_c);
  assign pin_e9_in = pin_e9_oe ? pin_e9_out : board_e9;
  assign pin_e10_in = pin_e10_oe ? pin_e10_out : board_e10;
endmodule : ppfc_board_model
`default_nettype wire

// file: verif/ppfc_top_monitor.sv
// Concurrent checks on the ports of the port pin function controller.
// Assumes the register map and codes of ppfc_params.svh; bound into ppfc_top.
`timescale 1ns/100ps
`default_nettype none
`include "ppfc_params.svh"
module ppfc_top_monitor
  import ppfc_pkg::*;
#(
  parameter int PORT_F_PINS = 8
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic strap_ext_rom_off,
  input wire ppfc_addr_type reg_addr,
  input wire ppfc_reg_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire ppfc_reg_type reg_rdata,
  input wire logic [5:0] pullup_en_a_high,
  input wire logic [3:0] pin_c_out,
  input wire logic [3:0] pin_c_oe,
  input wire logic pin_e9_out,
  input wire logic pin_e9_oe,
  input wire logic pin_e10_in,
  input wire logic pin_e10_out,
  input wire logic pin_e10_oe,
  input wire logic [PORT_F_PINS-1:0] pin_f_level,
  input wire logic [PORT_F_PINS-1:0] analog_sampling,
  input wire logic [3:0] ext_bus_addr_hi,
  input wire logic serial_tx_2,
  input wire logic dma_request_3_level,
  input wire logic dma_request_3_edge,
  input wire logic timer_ch3_io_c_in,
  input wire logic eth_tx_clk_in
);
  ppfc_reg_type shadow_c;
  ppfc_reg_type shadow_e;
  default clocking cb @(posedge clk_sys); endclocking
  logic resetn_q;
  default disable iff (!resetn || !resetn_q);
  ////////////////////////////////////////////////////////////////////////////////
  // Checks start one edge after release, once the design has left reset
  always_ff @(posedge clk_sys) begin
    resetn_q <= resetn;
  end
  // Shadow of the mode registers, rebuilt from observed writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shadow_c <= strap_ext_rom_off ? `PPFC_RST_MODE_C_EXT : `PPFC_RST_MODE_C;
      shadow_e <= `PPFC_RST_MODE_E;
    end else if (reg_write && reg_addr == `PPFC_ADDR_MODE_C_LOW2) begin
      shadow_c <= reg_wdata & `PPFC_MASK_MODE_C;
    end else if (reg_write && reg_addr == `PPFC_ADDR_MODE_E_LOW) begin
      shadow_e <= reg_wdata & `PPFC_MASK_MODE_E;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_mode_readback: assert property (reg_read && reg_addr == `PPFC_ADDR_MODE_C_LOW2
    |=> reg_rdata == $past(shadow_c)) else $error("port C mode read back wrong");
  a_pullup_follow: assert property (reg_write && reg_addr == `PPFC_ADDR_PULLUP_A_HIGH
    |-> ##2 pullup_en_a_high == $past(reg_wdata[5:0], 2)) else $error("pull-up stale");
  a_level_live: assert property (reg_read && reg_addr == `PPFC_ADDR_LEVEL_F_LOW
    |=> reg_rdata == ppfc_reg_type'($past(pin_f_level | analog_sampling)))
    else $error("port F level read wrong");
  // Pin function decode
  a_c7_address: assert property (shadow_c[14:12] == `PPFC_FN_ADDR
    |=> pin_c_oe[3] && pin_c_out[3] == $past(ext_bus_addr_hi[3]))
    else $error("pin C7 not driving address");
  a_c6_prohibit: assert property (shadow_c[10:8] > `PPFC_FN_ADDR
    |=> !pin_c_oe[2] && !pin_c_out[2]) else $error("pin C6 driven on bad code");
  a_e9_prohibit: assert property (shadow_e[6:4] inside {3'h1, 3'h3, 3'h5, 3'h6}
    |=> !pin_e9_oe && !pin_e9_out) else $error("pin E9 driven on bad code");
  a_e10_serial: assert property (shadow_e[10:8] == `PPFC_FN_SERIAL
    |=> pin_e10_oe && pin_e10_out == $past(serial_tx_2)) else $error("serial not on E10");
  a_timer_input: assert property (shadow_e[10:8] == `PPFC_FN_TIMER
    |=> timer_ch3_io_c_in == $past(pin_e10_in)) else $error("timer input not forwarded");
  a_eth_quiet: assert property (shadow_e[10:8] != `PPFC_FN_ETH |=> !eth_tx_clk_in)
    else $error("tx clock input active while unselected");
  a_dma_level: assert property (shadow_e[10:8] == `PPFC_FN_DMA
    |=> dma_request_3_level == $past(pin_e10_in)) else $error("request level wrong");
  a_dma_edge: assert property (dma_request_3_edge == $fell(dma_request_3_level))
    else $error("request edge pulse wrong");
  // Main scenarios
  c_dma_edge: cover property (shadow_e[10:8] == `PPFC_FN_DMA ##1 dma_request_3_edge);
  c_level_read: cover property (reg_read && reg_addr == `PPFC_ADDR_LEVEL_F_LOW);
  c_addr_drive: cover property ($rose(pin_c_oe[3]));
endmodule : ppfc_top_monitor

bind ppfc_top ppfc_top_monitor #(.PORT_F_PINS(PORT_F_PINS)) i_monitor (.*);
`default_nettype wire

// file: verif/tb_port_pin_function_control.sv
// Self-checking bench of the port pin function controller.
// Assumes ppfc_top, the board model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "ppfc_params.svh"
module tb_port_pin_function_control
  import ppfc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic strap_ext_rom_off = 1'b1;
  ppfc_addr_type reg_addr = 4'h0;
  ppfc_reg_type reg_wdata = 16'h0000;
  logic reg_write = 1'b0, reg_read = 1'b0, pins_free = 1'b1;
  logic [3:0] board_c = 4'h0;
  logic board_e9 = 1'b0, board_e10 = 1'b0;
  logic [7:0] pin_f_level = 8'h00, analog_sampling = 8'h00;
  ppfc_reg_type reg_rdata;
  logic [5:0] pullup_en_a_high;
  logic [3:0] pin_c_in, pin_c_out, pin_c_oe, ext_bus_addr_hi;
  logic pin_e9_in, pin_e9_out, pin_e9_oe, pin_e10_in, pin_e10_out, pin_e10_oe;
  logic dma_acknowledge_2, timer_ch3_io_b_out, timer_ch3_io_b_oe, timer_ch3_io_c_out;
  logic timer_ch3_io_c_oe, spi_slave_select_3, serial_tx_2, eth_tx_enable;
  logic dma_request_3_level, dma_request_3_edge, timer_ch3_io_b_in, timer_ch3_io_c_in;
  logic eth_tx_clk_in;
  int seed = 32'h417cfa98;
  int fails = 0;
  int checks_done = 0;
  ppfc_top #(.PORT_F_PINS(8)) i_dut (.*);
  ppfc_board_model i_board (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and random board levels
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (pins_free) begin
      board_c <= 4'($random(seed));
      {board_e9, board_e10} <= 2'($random(seed));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles, comparison and verdict
  task automatic wr(input ppfc_addr_type a, input ppfc_reg_type d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input ppfc_addr_type a, output ppfc_reg_type d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic do_reset(input logic strap);
    @(posedge clk_sys);
    strap_ext_rom_off <= strap;
    resetn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : do_reset
  task automatic check(input ppfc_reg_type seen, input ppfc_reg_type exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // Expected output enables per function code, port direction left at 0
  function automatic logic exp_e10_oe(input ppfc_code_type c, input logic t_oe);
    case (c)
      `PPFC_FN_TIMER: return t_oe;
      `PPFC_FN_SPI, `PPFC_FN_SERIAL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : exp_e10_oe
  function automatic logic exp_e9_oe(input ppfc_code_type c, input logic t_oe);
    case (c)
      `PPFC_FN_TIMER: return t_oe;
      `PPFC_FN_DMA, `PPFC_FN_ETH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : exp_e9_oe
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    ppfc_code_type code;
    ppfc_reg_type data;
    ppfc_reg_type back;
    logic t_c_oe, t_b_oe, lvl, lvl9;
    int pulses;
    do_reset(1'b1);
    rd(`PPFC_ADDR_MODE_C_LOW2, data);
    check(data, `PPFC_RST_MODE_C_EXT);
    check(16'(pin_c_oe), 16'h000f);
    rd(`PPFC_ADDR_PULLUP_A_HIGH, data);
    check(data, `PPFC_RST_PULLUP);
    rd(4'hf, data);
    check(data, 16'h0000);
    do_reset(1'b0);
    rd(`PPFC_ADDR_MODE_C_LOW2, data);
    check(data, `PPFC_RST_MODE_C);
    for (int i = 0; i < 8; i++) begin
      data = 16'($random(seed));
      wr(`PPFC_ADDR_PULLUP_A_HIGH, data);
      @(posedge clk_sys);
      #1 check(16'(pullup_en_a_high), data & `PPFC_MASK_PULLUP);
      rd(`PPFC_ADDR_PULLUP_A_HIGH, back);
      check(back, data & `PPFC_MASK_PULLUP);
      pin_f_level <= 8'($random(seed));
      analog_sampling <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      wr(`PPFC_ADDR_LEVEL_F_LOW, 16'($random(seed)));
      rd(`PPFC_ADDR_LEVEL_F_LOW, back);
      check(back, {8'h00, pin_f_level | analog_sampling});
    end
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      wr(`PPFC_ADDR_MODE_C_LOW2, {1'b1, code, 1'b1, code, 8'h00});
      wr(`PPFC_ADDR_MODE_E_LOW, {5'h1f, code, 1'b1, code, 4'hf});
      rd(`PPFC_ADDR_MODE_C_LOW2, data);
      check(data, {1'b0, code, 1'b0, code, 8'h00});
      t_c_oe = timer_ch3_io_c_oe;
      t_b_oe = timer_ch3_io_b_oe;
      lvl = pin_e10_in;
      lvl9 = pin_e9_in;
      @(posedge clk_sys);
      #1 check(16'(pin_e10_oe), 16'(exp_e10_oe(code, t_c_oe)));
      check(16'(pin_e9_oe), 16'(exp_e9_oe(code, t_b_oe)));
      check(16'(dma_request_3_level), 16'((code == `PPFC_FN_DMA) ? lvl : 1'b1));
      check(16'(pin_c_oe[3:2]), 16'({2{code == `PPFC_FN_ADDR}}));
      check(16'(timer_ch3_io_b_in), 16'((code == `PPFC_FN_TIMER) && lvl9));
      check(16'(eth_tx_clk_in), 16'((code == `PPFC_FN_ETH) && lvl));
    end
    // Port function: every pin driven from the output latch, levels read back
    data = 16'($random(seed));
    wr(`PPFC_ADDR_PORT_DIR, 16'h003f);
    wr(`PPFC_ADDR_PORT_DATA, data);
    wr(`PPFC_ADDR_MODE_C_LOW2, 16'h0000);
    wr(`PPFC_ADDR_MODE_E_LOW, 16'h0000);
    @(posedge clk_sys);
    #1 check(16'({pin_e10_out, pin_e9_out, pin_c_out}), data & `PPFC_MASK_PORT);
    check(16'({pin_e10_oe, pin_e9_oe, pin_c_oe}), 16'h003f);
    rd(`PPFC_ADDR_PORT_LEVEL, back);
    check(back, data & `PPFC_MASK_PORT);
    wr(`PPFC_ADDR_PORT_DIR, 16'h0000);
    pins_free <= 1'b0;
    board_e10 <= 1'b0;
    wr(`PPFC_ADDR_MODE_E_LOW, 16'h0000);
    repeat (3) @(posedge clk_sys);
    wr(`PPFC_ADDR_MODE_E_LOW, {5'h00, `PPFC_FN_DMA, 8'h00});
    pulses = 0;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      #1 pulses += int'(dma_request_3_edge === 1'b1);
    end
    check(16'(pulses), 16'h0001);
    give_verdict;
  end
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end
endmodule : tb_port_pin_function_control
`default_nettype wire
